/* File: hdl/dtc_pin_sample.sv */
// pin synchroniser with once-per-machine-cycle falling edge detection
`timescale 1ns/1ps
module dtc_pin_sample #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // pins and sample strobe
  input  wire logic [W-1:0] pins_in,
  input  wire logic         sample_stb,
  // results
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  logic [W-1:0] sync1_ff;
  logic [W-1:0] sync2_ff;
  logic [W-1:0] samp_ff;
  logic [W-1:0] fall_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
    end
  end

  // high sample followed by low sample one machine cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      samp_ff <= '0;
      fall_ff <= '0;
    end else begin
      fall_ff <= '0;
      if (sample_stb) begin
        samp_ff <= sync2_ff;
        fall_ff <= samp_ff & ~sync2_ff;
      end
    end
  end

  assign level = sync2_ff;
  assign fall  = fall_ff;
endmodule // dtc_pin_sample

/* File: hdl/dtc_timers.sv */
// dual 16-bit timer/counter with byte registers on a classic Wishbone slave
`timescale 1ns/1ps
module dtc_timers
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST,
  // wishbone slave
  input  wire logic                 WB_CYC_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_WE_I,
  input  wire logic [DTC_ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic      [31:0]          WB_DAT_O,
  output logic                      WB_ACK_O,
  // external pins
  input  wire logic                 COUNT_PIN_A,
  input  wire logic                 COUNT_PIN_B,
  input  wire logic                 GATE_INPUT_A,
  input  wire logic                 GATE_INPUT_B,
  // interrupt controller side
  input  wire logic                 ISR_ENTRY_A,
  input  wire logic                 ISR_ENTRY_B,
  output logic                      OVF_FLAG_A,
  output logic                      OVF_FLAG_B
);

  logic [7:0]  ctl_ff;
  logic [7:0]  mode_ff;
  logic        csel_a_ff;
  logic        csel_b_ff;
  dtc_count_s  cnt_a_ff;
  dtc_count_s  cnt_b_ff;
  dtc_count_s  nxt_cnt_a;
  dtc_count_s  nxt_cnt_b;
  logic [3:0]  pre_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;

  logic        req;
  logic        wr_en;
  logic [7:0]  idx;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  dtc_tcfg_s   cfg_a;
  dtc_tcfg_s   cfg_b;
  logic        split;
  logic        tick12;
  logic        tick4;
  logic        ttick_a;
  logic        ttick_b;
  logic [1:0]  gate_lvl;
  logic [1:0]  pin_fall;
  logic        adv_a;
  logic        adv_b;
  logic        adv_ah;
  logic        ovf_a;
  logic        ovf_ah;
  logic        ovf_b;
  logic        set_fa;
  logic        set_fb;
  logic [16:0] step_a;
  logic [16:0] step_b;

  // one increment in modes 0 to 2; mode 3 holds (split handled apart)
  function automatic logic [16:0] step(dtc_mode_e m, dtc_count_s c);
    logic [16:0] r;
    r = {1'b0, c};
    case (m)
      DTC_M13: begin
        r[DTC_PRE_W-1:0] = c.lo[DTC_PRE_W-1:0] + 5'h01;
        if (&c.lo[DTC_PRE_W-1:0]) begin
          r[16:8] = {1'b0, c.hi} + 9'h001;
        end
      end
      DTC_M16: r = {1'b0, c} + 17'h00001;
      DTC_MRELOAD: begin
        r = {1'b0, c.hi, c.lo + 8'h01};
        if (&c.lo) begin
          r = {1'b1, c.hi, c.hi};
        end
      end
      default: r = {1'b0, c};
    endcase
    return r;
  endfunction

  function automatic logic wr_to(logic en, logic [7:0] i, logic [7:0] reg_idx);
    return en && (i == reg_idx);
  endfunction

  // bus front end: ack one cycle after the request, write lands on the ack edge
  assign req   = WB_CYC_I & WB_STB_I;
  assign idx   = WB_ADR_I[DTC_IDX_LSB +: 8];
  assign wbyte = WB_DAT_I[7:0];
  assign wr_en = req & ack_ff & WB_WE_I & WB_SEL_I[0];

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_comb begin
    case (idx)
      DTC_IDX_CONTROL: rd_byte = ctl_ff;
      DTC_IDX_MODE:    rd_byte = mode_ff;
      DTC_IDX_A_LOW:   rd_byte = cnt_a_ff.lo;
      DTC_IDX_A_HIGH:  rd_byte = cnt_a_ff.hi;
      DTC_IDX_B_LOW:   rd_byte = cnt_b_ff.lo;
      DTC_IDX_B_HIGH:  rd_byte = cnt_b_ff.hi;
      DTC_IDX_CLKDIV: begin
        rd_byte          = DTC_RST_BYTE;
        rd_byte[DTC_CSA] = csel_a_ff;
        rd_byte[DTC_CSB] = csel_b_ff;
      end
      default:         rd_byte = DTC_RST_BYTE;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dat_ff <= 32'h0000_0000;
    end else if (req & ~ack_ff) begin
      dat_ff <= {24'h00_0000, rd_byte};
    end
  end

  // machine cycle of 12 core clocks; turbo tick every 4
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pre_ff <= 4'h0;
    end else if (pre_ff == DTC_MC_LAST) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  assign tick12  = (pre_ff == DTC_MC_LAST);
  assign tick4   = (pre_ff[1:0] == DTC_TURBO_PH);
  assign ttick_a = csel_a_ff ? tick4 : tick12;
  assign ttick_b = csel_b_ff ? tick4 : tick12;

  dtc_pin_sample #(.W(2)) u_cnt_pins (
    .clk        (CORE_CLK),
    .rst        (RST),
    .pins_in    ({COUNT_PIN_B, COUNT_PIN_A}),
    .sample_stb (tick12),
    .level      (),
    .fall       (pin_fall)
  );

  dtc_pin_sample #(.W(2)) u_gate_pins (
    .clk        (CORE_CLK),
    .rst        (RST),
    .pins_in    ({GATE_INPUT_B, GATE_INPUT_A}),
    .sample_stb (tick12),
    .level      (gate_lvl),
    .fall       ()
  );

  assign cfg_a = dtc_tcfg_s'(mode_ff[DTC_CFG_W-1:0]);
  assign cfg_b = dtc_tcfg_s'(mode_ff[DTC_CFG_B_LSB +: DTC_CFG_W]);
  assign split = (cfg_a.mode == DTC_MSPLIT);

  // count enables; in split mode timer B loses its run bit and runs freely
  assign adv_a  = ctl_ff[DTC_TRA] & (~cfg_a.gate | gate_lvl[0])
                  & (cfg_a.ctr ? pin_fall[0] : ttick_a);
  assign adv_b  = (split | ctl_ff[DTC_TRB]) & (~cfg_b.gate | gate_lvl[1])
                  & (cfg_b.ctr ? pin_fall[1] : ttick_b)
                  & (cfg_b.mode != DTC_MSPLIT);
  assign adv_ah = split & ctl_ff[DTC_TRB] & ttick_a;

  assign step_a = step(cfg_a.mode, cnt_a_ff);
  assign step_b = step(cfg_b.mode, cnt_b_ff);

  always_comb begin
    nxt_cnt_a = cnt_a_ff;
    ovf_a     = 1'b0;
    ovf_ah    = 1'b0;
    if (split) begin
      if (adv_a) begin
        {ovf_a, nxt_cnt_a.lo} = {1'b0, cnt_a_ff.lo} + 9'h001;
      end
      if (adv_ah) begin
        {ovf_ah, nxt_cnt_a.hi} = {1'b0, cnt_a_ff.hi} + 9'h001;
      end
    end else if (adv_a) begin
      {ovf_a, nxt_cnt_a} = step_a;
    end
  end

  always_comb begin
    nxt_cnt_b = cnt_b_ff;
    ovf_b     = 1'b0;
    if (adv_b) begin
      {ovf_b, nxt_cnt_b} = step_b;
    end
  end

  assign set_fa = ovf_a;
  assign set_fb = split ? ovf_ah : (ovf_b & ~split);

  // software byte writes take priority over a same-cycle increment
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_a_ff <= '0;
    end else begin
      cnt_a_ff <= nxt_cnt_a;
      if (wr_to(wr_en, idx, DTC_IDX_A_LOW)) begin
        cnt_a_ff.lo <= wbyte;
      end
      if (wr_to(wr_en, idx, DTC_IDX_A_HIGH)) begin
        cnt_a_ff.hi <= wbyte;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_b_ff <= '0;
    end else begin
      cnt_b_ff <= nxt_cnt_b;
      if (wr_to(wr_en, idx, DTC_IDX_B_LOW)) begin
        cnt_b_ff.lo <= wbyte;
      end
      if (wr_to(wr_en, idx, DTC_IDX_B_HIGH)) begin
        cnt_b_ff.hi <= wbyte;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mode_ff   <= DTC_RST_BYTE;
      csel_a_ff <= 1'b0;
      csel_b_ff <= 1'b0;
    end else begin
      if (wr_to(wr_en, idx, DTC_IDX_MODE)) begin
        mode_ff <= wbyte;
      end
      if (wr_to(wr_en, idx, DTC_IDX_CLKDIV)) begin
        csel_a_ff <= wbyte[DTC_CSA];
        csel_b_ff <= wbyte[DTC_CSB];
      end
    end
  end

  // an overflow in the clearing cycle still leaves the flag set
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctl_ff <= DTC_RST_BYTE;
    end else begin
      if (wr_to(wr_en, idx, DTC_IDX_CONTROL)) begin
        ctl_ff <= wbyte;
      end else begin
        if (ISR_ENTRY_A) begin
          ctl_ff[DTC_TFA] <= 1'b0;
        end
        if (ISR_ENTRY_B) begin
          ctl_ff[DTC_TFB] <= 1'b0;
        end
      end
      if (set_fa) begin
        ctl_ff[DTC_TFA] <= 1'b1;
      end
      if (set_fb) begin
        ctl_ff[DTC_TFB] <= 1'b1;
      end
    end
  end

  assign WB_ACK_O   = ack_ff;
  assign WB_DAT_O   = dat_ff;
  assign OVF_FLAG_A = ctl_ff[DTC_TFA];
  assign OVF_FLAG_B = ctl_ff[DTC_TFB];

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_run_b_free;
    ctl_ff[DTC_TRB] && !cfg_b.gate && !cfg_b.ctr && cfg_b.mode == DTC_M16 && ttick_b && !split && !wr_en
      |=> cnt_b_ff == $past(cnt_b_ff) + 16'h0001;
  endproperty
  a_run_b_free: assert property (p_run_b_free) else $error("timer B did not count");

  property p_gate_b;
    cfg_b.gate && !gate_lvl[1] && !wr_en |=> $stable(cnt_b_ff);
  endproperty
  a_gate_b: assert property (p_gate_b) else $error("timer B counted with gate low");

  property p_run_a_free;
    ctl_ff[DTC_TRA] && !cfg_a.gate && !cfg_a.ctr && cfg_a.mode == DTC_M16 && ttick_a && !wr_en
      |=> cnt_a_ff == $past(cnt_a_ff) + 16'h0001;
  endproperty
  a_run_a_free: assert property (p_run_a_free) else $error("timer A did not count");

  property p_gate_a;
    cfg_a.gate && !gate_lvl[0] && !split && !wr_en |=> $stable(cnt_a_ff);
  endproperty
  a_gate_a: assert property (p_gate_a) else $error("timer A counted with gate low");

  property p_stop_a;
    !ctl_ff[DTC_TRA] && !split && !wr_en |=> $stable(cnt_a_ff);
  endproperty
  a_stop_a: assert property (p_stop_a) else $error("stopped timer A moved");

  property p_halt_b;
    (cfg_b.mode == DTC_MSPLIT || (!ctl_ff[DTC_TRB] && !split)) && !wr_en [*2] |-> $stable(cnt_b_ff);
  endproperty
  a_halt_b: assert property (p_halt_b) else $error("halted timer B moved");

  property p_wrap13;
    cfg_a.mode == DTC_M13 && adv_a && cnt_a_ff.hi == 8'hff && &cnt_a_ff.lo[DTC_PRE_W-1:0] && !wr_en
      |=> cnt_a_ff.hi == 8'h00 && cnt_a_ff.lo[DTC_PRE_W-1:0] == 5'h00 && OVF_FLAG_A;
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("13-bit wrap wrong");

  property p_reload;
    cfg_a.mode == DTC_MRELOAD && adv_a && &cnt_a_ff.lo && !wr_en
      |=> cnt_a_ff.lo == $past(cnt_a_ff.hi) && $stable(cnt_a_ff.hi) && OVF_FLAG_A;
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload wrong");

  property p_flag_b_split;
    split && adv_ah && &cnt_a_ff.hi |=> OVF_FLAG_B;
  endproperty
  a_flag_b_split: assert property (p_flag_b_split) else $error("split high overflow lost");

  property p_pin_edge;
    $rose(pin_fall[0]) |-> $past(tick12);
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("edge outside machine cycle");

  property p_ack_once;
    ack_ff |=> !ack_ff;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  c_reload: cover property (cfg_a.mode == DTC_MRELOAD && adv_a && &cnt_a_ff.lo);
  c_split_hi: cover property (split && adv_ah && &cnt_a_ff.hi);
  c_pin_count: cover property (cfg_b.ctr && adv_b);
endmodule // dtc_timers

/* File: include/dtc_pkg.sv */
// constants, types and register map of the dual timer/counter
package dtc_pkg;

  // bus geometry: register index sits at byte address index*4
  localparam int unsigned DTC_ADR_W = 10;
  localparam int unsigned DTC_IDX_LSB = 2;

  // register indices
  localparam logic [7:0] DTC_IDX_CONTROL = 8'h88;
  localparam logic [7:0] DTC_IDX_MODE    = 8'h89;
  localparam logic [7:0] DTC_IDX_A_LOW   = 8'h8a;
  localparam logic [7:0] DTC_IDX_B_LOW   = 8'h8b;
  localparam logic [7:0] DTC_IDX_A_HIGH  = 8'h8c;
  localparam logic [7:0] DTC_IDX_B_HIGH  = 8'h8d;
  localparam logic [7:0] DTC_IDX_CLKDIV  = 8'h8e;

  // timer_control bit positions
  localparam int unsigned DTC_TFB = 7;
  localparam int unsigned DTC_TRB = 6;
  localparam int unsigned DTC_TFA = 5;
  localparam int unsigned DTC_TRA = 4;

  // clock_divide_control bit positions
  localparam int unsigned DTC_CSB = 4;
  localparam int unsigned DTC_CSA = 3;

  // timer_mode nibble positions
  localparam int unsigned DTC_CFG_B_LSB = 4;
  localparam int unsigned DTC_CFG_W     = 4;

  localparam logic [7:0] DTC_RST_BYTE = 8'h00;

  // core clock and tick division
  localparam int unsigned DTC_CLK_HZ    = 10_000_000;
  localparam logic [3:0]  DTC_MC_LAST   = 4'hb;
  localparam logic [1:0]  DTC_TURBO_PH  = 2'h3;
  localparam int unsigned DTC_PRE_W     = 5;

  typedef enum logic [1:0] {
    DTC_M13     = 2'b00,
    DTC_M16     = 2'b01,
    DTC_MRELOAD = 2'b10,
    DTC_MSPLIT  = 2'b11
  } dtc_mode_e;

  typedef struct packed {
    logic      gate;
    logic      ctr;
    dtc_mode_e mode;
  } dtc_tcfg_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_count_s;

endpackage

/* File: test/dtc_pin_model.sv */
// far-side model of the count and gate pins
`timescale 1ns/1ps
module dtc_pin_model (
  // clock
  input  wire logic       clk,
  // pins, index 0 timer a, 1 timer b
  output logic      [1:0] count_pin,
  output logic      [1:0] gate_pin
);
  // count pins rest high as if pulled up, gates start closed
  initial begin
    count_pin = 2'b11;
    gate_pin  = 2'b00;
  end

  // each level lasts two machine cycles so no edge is missed
  task automatic pulses(input int t, input int n);
    repeat (n) begin
      count_pin[t] <= 1'b0;
      repeat (24) @(posedge clk);
      count_pin[t] <= 1'b1;
      repeat (24) @(posedge clk);
    end
  endtask

  task automatic gate(input int t, input logic v);
    gate_pin[t] <= v;
    @(posedge clk);
  endtask
endmodule // dtc_pin_model

/* File: test/dtc_timers_tb_top.sv */
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module dtc_timers_tb_top;
  import dtc_pkg::*;
  logic                 core_clk = 1'b0;
  logic                 rst      = 1'b1;
  logic                 cyc      = 1'b0;
  logic                 stb      = 1'b0;
  logic                 we       = 1'b0;
  logic [DTC_ADR_W-1:0] adr      = '0;
  logic [3:0]           sel      = 4'h0;
  logic [31:0]          dat_w    = 32'h0;
  logic [1:0]           isr      = 2'h0;
  logic [31:0]          dat_r;
  logic                 ack;
  logic                 flag_a;
  logic                 flag_b;
  logic [1:0]           cpin;
  logic [1:0]           gpin;
  int                   errors   = 0;
  int                   n_tests  = 0;

  always #50 core_clk = ~core_clk;

  dtc_timers uut (
    .CORE_CLK(core_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .COUNT_PIN_A(cpin[0]), .COUNT_PIN_B(cpin[1]), .GATE_INPUT_A(gpin[0]), .GATE_INPUT_B(gpin[1]),
    .ISR_ENTRY_A(isr[0]), .ISR_ENTRY_B(isr[1]), .OVF_FLAG_A(flag_a), .OVF_FLAG_B(flag_b)
  );

  dtc_pin_model pm (.clk(core_clk), .count_pin(cpin), .gate_pin(gpin));

  function automatic logic [7:0] lo(int t);
    return t ? DTC_IDX_B_LOW : DTC_IDX_A_LOW;
  endfunction
  function automatic logic [7:0] hi(int t);
    return t ? DTC_IDX_B_HIGH : DTC_IDX_A_HIGH;
  endfunction
  function automatic logic fl(int t);
    return t ? flag_b : flag_a;
  endfunction

  task automatic report_and_stop;
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; a dead slave is caught by the watchdog, not here
  task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d, output logic [7:0] q);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {ix, 2'b00};
    dat_w <= {24'h0, d};
    sel   <= 4'hf;
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, ix, d, q);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [7:0] e, input string nm);
    logic [7:0] q;
    wb(1'b0, ix, 8'h0, q);
    chk(nm, e, q);
  endtask

  task automatic wait_flag(input int t, input int lim);
    int n;
    n = 0;
    while (fl(t) !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk("overflow flag", 8'h1, {7'h0, fl(t)});
  endtask

  task automatic prep(input int t, input logic [7:0] m, input logic [7:0] h, input logic [7:0] l);
    wr(DTC_IDX_CONTROL, 8'h00);
    wr(DTC_IDX_MODE, m << (4 * t));
    wr(hi(t), h);
    wr(lo(t), l);
    wr(DTC_IDX_CONTROL, 8'h10 << (2 * t));
  endtask

  task automatic t_regs;
    for (int k = 0; k < 7; k++) rd(DTC_IDX_CONTROL + 8'(k), 8'h00, "reset value");
    wr(8'h90, 8'hff);
    rd(8'h90, 8'h00, "unmapped");
    wr(DTC_IDX_CONTROL, 8'h0f);
    rd(DTC_IDX_CONTROL, 8'h0f, "control low nibble");
    wr(DTC_IDX_MODE, 8'ha5);
    rd(DTC_IDX_MODE, 8'ha5, "mode");
    for (int k = 2; k < 6; k++) wr(DTC_IDX_CONTROL + 8'(k), 8'h30 + 8'(k));
    for (int k = 2; k < 6; k++) rd(DTC_IDX_CONTROL + 8'(k), 8'h30 + 8'(k), "count byte");
  endtask

  // gate input low and gate bit clear: the timer must still run
  task automatic t_ovf(input int t);
    logic [7:0] v1;
    logic [7:0] v2;
    prep(t, 8'h01, 8'hff, 8'hfe);
    wait_flag(t, 40);
    isr[t] <= 1'b1;
    @(posedge core_clk);
    isr[t] <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("flag after service", 8'h0, {7'h0, fl(t)});
    wr(DTC_IDX_CONTROL, 8'h20 << (2 * t));
    chk("flag set by write", 8'h1, {7'h0, fl(t)});
    wr(DTC_IDX_CONTROL, 8'h00);
    chk("flag cleared by write", 8'h0, {7'h0, fl(t)});
    wb(1'b0, lo(t), 8'h0, v1);
    repeat (40) @(posedge core_clk);
    wb(1'b0, lo(t), 8'h0, v2);
    chk("count held when stopped", v1, v2);
  endtask

  task automatic t_gate(input int t);
    logic [7:0] v;
    prep(t, 8'h09, 8'h00, 8'h00);
    repeat (50) @(posedge core_clk);
    rd(lo(t), 8'h00, "gate closed");
    pm.gate(t, 1'b1);
    repeat (50) @(posedge core_clk);
    wb(1'b0, lo(t), 8'h0, v);
    chk("gate open", 8'h1, {7'h0, v != 8'h00});
    pm.gate(t, 1'b0);
  endtask

  task automatic t_ctr(input int t);
    prep(t, 8'h05, 8'h00, 8'h00);
    pm.pulses(t, 3);
    rd(lo(t), 8'h03, "pin edges");
  endtask

  task automatic t_reload(input int t);
    prep(t, 8'h02, 8'hf0, 8'hfe);
    wait_flag(t, 40);
    rd(lo(t), 8'hf0, "reloaded low");
    rd(hi(t), 8'hf0, "reload source");
  endtask

  // fast tick: the wrap must come within two /4 periods
  task automatic t_m13(input int t);
    wr(DTC_IDX_CLKDIV, 8'h18);
    prep(t, 8'h00, 8'hff, 8'h1f);
    wait_flag(t, 7);
    rd(hi(t), 8'h00, "13-bit wrap");
    wr(DTC_IDX_CLKDIV, 8'h00);
  endtask

  task automatic t_mode3;
    prep(1, 8'h03, 8'h00, 8'h00);
    repeat (50) @(posedge core_clk);
    rd(lo(1), 8'h00, "timer b halted");
    // run A is never set here, so a stray tick cannot move the split low byte
    wr(DTC_IDX_CONTROL, 8'h00);
    wr(DTC_IDX_MODE, 8'h03);
    wr(hi(0), 8'hfe);
    wr(lo(0), 8'h00);
    wr(DTC_IDX_CONTROL, 8'h40);
    wait_flag(1, 40);
    chk("split flag a", 8'h0, {7'h0, fl(0)});
    rd(lo(0), 8'h00, "split low idle");
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    for (int t = 0; t < 2; t++) begin
      t_ovf(t);
      t_gate(t);
      t_ctr(t);
      t_reload(t);
      t_m13(t);
    end
    t_mode3();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end
endmodule // dtc_timers_tb_top
